// ===== include/spi_flash_defs.svh
// spi_flash_defs.svh - opcodes, field positions, erase masks and lengths and timing counts
// of the serial flash command engine.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef SPI_FLASH_DEFS_SVH
`define SPI_FLASH_DEFS_SVH

// opcodes
`define OP_READ_FAST       8'h0B
`define OP_READ_SLOW       8'h03
`define OP_PROGRAM         8'h02
`define OP_ERASE_4K        8'h20
`define OP_ERASE_32K_A     8'h52
`define OP_ERASE_32K_B     8'hD8
`define OP_CHIP_ERASE_A    8'h60
`define OP_CHIP_ERASE_B    8'h62
`define OP_CHIP_ERASE_C    8'hC7
`define OP_WRITE_ENABLE    8'h06
`define OP_WRITE_DISABLE   8'h04
`define OP_READ_STATUS     8'h05

// byte positions in a frame (count of completed bytes)
`define IDX_OPCODE_DONE    3'h1
`define IDX_ADDR_LAST      3'h3
`define IDX_ADDR_DONE      3'h4

// status byte layout
`define STAT_BUSY_BIT      0
`define STAT_LATCH_BIT     1
`define STAT_ERR_BIT       5

// erase region alignment masks over the 16-bit array address
`define MASK_4K            16'hF000
`define MASK_32K           16'h8000
`define LEN_PAGE           17'h00100
`define LEN_4K             17'h01000
`define LEN_32K            17'h08000
`define LEN_CHIP           17'h10000
`define ERASED_BYTE        8'hFF

// timing: figures in their own unit, cycles derived from the core rate
`define CORE_CLK_KHZ                   10000
`define PAGE_PROGRAM_TIME_US           2500
`define SINGLE_BYTE_PROGRAM_TIME_US    100
`define BLOCK_ERASE_4K_TIME_MS         100
`define BLOCK_ERASE_32K_TIME_MS        500
`define FULL_ARRAY_ERASE_TIME_MS       1000
`define PAGE_PROGRAM_CYCLES  (`PAGE_PROGRAM_TIME_US * `CORE_CLK_KHZ / 1000)
`define BYTE_PROGRAM_CYCLES  (`SINGLE_BYTE_PROGRAM_TIME_US * `CORE_CLK_KHZ / 1000)
`define ERASE_4K_CYCLES      (`BLOCK_ERASE_4K_TIME_MS * `CORE_CLK_KHZ)
`define ERASE_32K_CYCLES     (`BLOCK_ERASE_32K_TIME_MS * `CORE_CLK_KHZ)
`define CHIP_ERASE_CYCLES    (`FULL_ARRAY_ERASE_TIME_MS * `CORE_CLK_KHZ)

`endif

// ===== include/spi_flash_pkg.sv
// spi_flash_pkg - types shared by the flash command engine.
// Assumes spi_flash_defs.svh supplies the numeric constants.
package spi_flash_pkg;

    // core sequencer states, one-hot
    typedef enum logic [2:0] {
        CORE_IDLE = 3'h1,
        CORE_WALK = 3'h2,
        CORE_HOLD = 3'h4
    } core_state_type;

    // what the link side knows about the current or last frame
    typedef struct packed {
        logic [7:0]  opcode;
        logic [15:0] addr;
        logic [2:0]  byte_idx;   // completed bytes, saturates at 7
        logic [1:0]  data_cnt;   // program data bytes, saturates at 3
        logic        blocked;    // opcode other than 05h arrived while busy
    } frame_type;

    // status bits handed to the link side
    typedef struct packed {
        logic busy;
        logic latch;
        logic err;
    } status_type;

endpackage : spi_flash_pkg

// ===== hdl/spi_flash_engine.sv
// spi_flash_engine - serial flash command engine: array read, page program,
// block and chip erase, status read, write-enable latch and error flag.
// Assumes an SPI host in mode 0 or 3 and chip select high for at least
// eight core clock periods between frames.
//
// Behaviour
// - accept fast 0Bh and slow 03h reads
// - stream data MSB first, auto-increment address
// - address rolls from 00FFFFh to 000000h
// - chip select rise ends read, floats output
// - 02h plus address fills 256-byte page buffer
// - program data wraps within same page
// - buffer keeps the last 256 bytes
// - program only written locations at deselect
// - incomplete or misaligned program aborts, clears latch
// - protected array refuses program and erase
// - busy during cycle, latch cleared before end
// - verify every written location, flag failures
// - 20h 4K erase, 52h/D8h 32K erase
// - ignore low address bits per erase size
// - short or misaligned erase aborts, clears latch
// - 60h 62h C7h are chip erase
// - misaligned chip erase refused, latch cleared
// - program and erase need the latch set
// - erase runs self-timed from deselect, sets ones
// - sample input rising, drive output falling
// - address bits A23-A16 ignored
// - unknown opcodes ignored until next frame
`include "spi_flash_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module spi_flash_engine #(
    parameter int unsigned PAGE_PROGRAM_CYCLES = `PAGE_PROGRAM_CYCLES,
    parameter int unsigned BYTE_PROGRAM_CYCLES = `BYTE_PROGRAM_CYCLES,
    parameter int unsigned ERASE_4K_CYCLES     = `ERASE_4K_CYCLES,
    parameter int unsigned ERASE_32K_CYCLES    = `ERASE_32K_CYCLES,
    parameter int unsigned CHIP_ERASE_CYCLES   = `CHIP_ERASE_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic array_protect,
    output var  logic so,
    output var  logic so_oe,
    output var  logic busy,
    output var  logic write_enable_latch,
    output var  logic program_erase_error_flag
);

    // array, written by the core side, read by the link side (dual port)
    logic [7:0]                 mem [0:65535];
    logic [7:0]                 page_buf [0:255];
    logic [255:0]               page_written;

    // link side state
    logic                       link_rst;
    logic                       first_edge;
    logic                       frame_tog;
    logic [2:0]                 bit_cnt;
    logic [6:0]                 shift_in;
    spi_flash_pkg::frame_type   frame;
    logic [7:0]                 pg_ptr;
    logic [15:0]                rd_addr;
    logic [7:0]                 out_byte;
    logic                       out_active;
    spi_flash_pkg::status_type  st_meta;
    spi_flash_pkg::status_type  st_sync;
    logic [2:0]                 cur_bit;
    logic [2:0]                 cur_idx;
    logic                       byte_done;
    logic [7:0]                 in_byte;
    logic [7:0]                 status_byte;
    logic                       prog_accept;

    // core side state
    logic                       cs_meta;
    logic                       cs_sync;
    logic                       cs_prev;
    logic                       prot_meta;
    logic                       prot_sync;
    logic                       seen_tog;
    spi_flash_pkg::core_state_type state;
    logic                       walk_prog;
    logic [15:0]                walk_ptr;
    logic [16:0]                walk_left;
    logic [31:0]                hold_cnt;
    logic                       chk_valid;
    logic [15:0]                chk_addr;
    logic [7:0]                 chk_val;
    logic                       frame_end;
    logic                       frame_valid;
    logic                       aligned;
    logic                       has_op;
    logic                       is_prog;
    logic                       is_blk4;
    logic                       is_blk32;
    logic                       is_chip;
    logic                       pe_req;
    logic                       pe_ok;
    logic                       pe_start;
    logic                       walk_last;

    //------------------------------------------------------------------
    // link side, clocked by sck
    //------------------------------------------------------------------

    // chip select high clears only the frame-start marker and the driver
    assign link_rst = rst | cs_n;

    // position within the frame as seen by this edge
    assign cur_bit   = first_edge ? 3'h0 : bit_cnt;
    assign cur_idx   = first_edge ? 3'h0 : frame.byte_idx;
    assign byte_done = (cur_bit == 3'h7);
    assign in_byte   = {shift_in, si};
    assign status_byte = {2'h0, st_sync.err, 3'h0, st_sync.latch, st_sync.busy};
    // buffer only fills for an accepted program frame
    assign prog_accept = (frame.opcode == `OP_PROGRAM) && !frame.blocked;

    // frame-start marker: set while deselected, cleared on first edge
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            first_edge <= 1'b1;
        end else begin
            first_edge <= 1'b0;
        end
    end

    // bit counter and input shifter, sampled on the rising edge
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            bit_cnt   <= 3'h0;
            shift_in  <= 7'h00;
            frame_tog <= 1'b0;
        end else begin
            bit_cnt  <= cur_bit + 3'h1;
            shift_in <= {shift_in[5:0], si};
            if (first_edge) begin
                frame_tog <= ~frame_tog; // tells the core a frame had clocks
            end
        end
    end

    // opcode, address and counters; kept after deselect for the core to read
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            frame <= '0;
        end else begin
            if (first_edge) begin
                frame.byte_idx <= 3'h0;
                frame.data_cnt <= 2'h0;
            end
            if (byte_done) begin
                if (cur_idx != 3'h7) begin
                    frame.byte_idx <= cur_idx + 3'h1;
                end
                if (cur_idx == 3'h0) begin
                    frame.opcode  <= in_byte;
                    frame.blocked <= st_sync.busy && (in_byte != `OP_READ_STATUS);
                end else if (cur_idx <= `IDX_ADDR_LAST) begin
                    frame.addr <= {frame.addr[7:0], in_byte};
                end else if (prog_accept && frame.data_cnt != 2'h3) begin
                    frame.data_cnt <= frame.data_cnt + 2'h1;
                end
            end
        end
    end

    // page buffer pointer and written mask
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            pg_ptr       <= 8'h00;
            page_written <= '0;
        end else if (byte_done) begin
            if (cur_idx == 3'h0 && in_byte == `OP_PROGRAM && !st_sync.busy) begin
                page_written <= '0; // cleared only when a new program may start
            end else if (cur_idx == `IDX_ADDR_LAST) begin
                pg_ptr <= in_byte;
            end else if (cur_idx >= `IDX_ADDR_DONE && prog_accept) begin
                page_written[pg_ptr] <= 1'b1;
                pg_ptr <= pg_ptr + 8'h01;
            end
        end
    end

    // buffer data; later bytes overwrite earlier ones at the same slot
    always_ff @(posedge sck) begin
        if (byte_done && cur_idx >= `IDX_ADDR_DONE && prog_accept) begin
            page_buf[pg_ptr] <= in_byte;
        end
    end

    // read data and status source, loaded when a byte completes
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            rd_addr    <= 16'h0000;
            out_byte   <= 8'h00;
            out_active <= 1'b0;
        end else if (first_edge) begin
            out_active <= 1'b0;
        end else if (byte_done) begin
            if (cur_idx == 3'h0 && in_byte == `OP_READ_STATUS) begin
                out_byte   <= status_byte;
                out_active <= 1'b1;
            end else if (frame.opcode == `OP_READ_STATUS) begin
                out_byte <= status_byte;
            end else if (frame.blocked) begin
                out_active <= 1'b0;
            end else if ((frame.opcode == `OP_READ_SLOW && cur_idx == `IDX_ADDR_LAST)) begin
                out_byte   <= mem[{frame.addr[7:0], in_byte}];
                rd_addr    <= {frame.addr[7:0], in_byte} + 16'h0001;
                out_active <= 1'b1;
            end else if (frame.opcode == `OP_READ_FAST && cur_idx == `IDX_ADDR_DONE) begin
                out_byte   <= mem[frame.addr];
                rd_addr    <= frame.addr + 16'h0001;
                out_active <= 1'b1;
            end else if (out_active) begin
                out_byte <= mem[rd_addr];
                rd_addr  <= rd_addr + 16'h0001;
            end
        end
    end

    // output driver on the falling edge; deselect floats it at once
    always_ff @(negedge sck or posedge link_rst) begin
        if (link_rst) begin
            so_oe <= 1'b0;
        end else begin
            so_oe <= out_active && !first_edge;
        end
    end

    // serial data, MSB first
    always_ff @(negedge sck or posedge rst) begin
        if (rst) begin
            so <= 1'b0;
        end else begin
            so <= out_byte[3'h7 - bit_cnt];
        end
    end

    // core status into the link domain; sck only runs inside frames
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            st_meta <= '0;
            st_sync <= '0;
        end else begin
            st_meta <= '{busy: busy, latch: write_enable_latch, err: program_erase_error_flag};
            st_sync <= st_meta;
        end
    end

    //------------------------------------------------------------------
    // core side, clocked by core_clk
    //------------------------------------------------------------------

    // chip select and protect pin synchronisers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cs_meta   <= 1'b1;
            cs_sync   <= 1'b1;
            cs_prev   <= 1'b1;
            prot_meta <= 1'b0;
            prot_sync <= 1'b0;
        end else begin
            cs_meta   <= cs_n;
            cs_sync   <= cs_meta;
            cs_prev   <= cs_sync;
            prot_meta <= array_protect;
            prot_sync <= prot_meta;
        end
    end

    // frame summary is quiet once chip select is high, so read it directly
    assign frame_end   = cs_sync && !cs_prev;
    assign frame_valid = frame_end && (frame_tog != seen_tog) && (state == spi_flash_pkg::CORE_IDLE);
    assign aligned     = (bit_cnt == 3'h0);
    assign has_op      = (frame.byte_idx >= `IDX_OPCODE_DONE);
    assign is_prog     = (frame.opcode == `OP_PROGRAM);
    assign is_blk4     = (frame.opcode == `OP_ERASE_4K);
    assign is_blk32    = (frame.opcode == `OP_ERASE_32K_A) || (frame.opcode == `OP_ERASE_32K_B);
    assign is_chip     = (frame.opcode == `OP_CHIP_ERASE_A) || (frame.opcode == `OP_CHIP_ERASE_B)
                       || (frame.opcode == `OP_CHIP_ERASE_C);
    // unknown opcodes fall through every decode and do nothing
    assign pe_req      = frame_valid && has_op && write_enable_latch
                       && (is_prog || is_blk4 || is_blk32 || is_chip);
    assign pe_ok       = aligned && !prot_sync
                       && (!is_prog || (frame.byte_idx >= `IDX_ADDR_DONE
                                        && frame.data_cnt != 2'h0))
                       && (is_prog || is_chip || frame.byte_idx >= `IDX_ADDR_DONE);
    assign pe_start    = pe_req && pe_ok;
    assign walk_last   = (state == spi_flash_pkg::CORE_WALK) && (walk_left == 17'h00001);

    // frame bookkeeping
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seen_tog <= 1'b0;
        end else if (frame_end) begin
            seen_tog <= frame_tog;
        end
    end

    // write-enable latch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            write_enable_latch <= 1'b0;
        end else if (pe_req) begin
            write_enable_latch <= 1'b0;
        end else if (frame_valid && has_op && aligned) begin
            if (frame.opcode == `OP_WRITE_ENABLE) begin
                write_enable_latch <= 1'b1;
            end else if (frame.opcode == `OP_WRITE_DISABLE) begin
                write_enable_latch <= 1'b0;
            end
        end
    end

    // sequencer: walk the target region, then hold busy for the full time
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state     <= spi_flash_pkg::CORE_IDLE;
            busy      <= 1'b0;
            walk_prog <= 1'b0;
            walk_ptr  <= 16'h0000;
            walk_left <= 17'h00000;
            hold_cnt  <= 32'h00000000;
        end else begin
            case (state)
                spi_flash_pkg::CORE_IDLE: begin
                    if (pe_start) begin
                        state     <= spi_flash_pkg::CORE_WALK;
                        busy      <= 1'b1;
                        walk_prog <= is_prog;
                        if (is_prog) begin
                            walk_ptr  <= {frame.addr[15:8], 8'h00};
                            walk_left <= `LEN_PAGE;
                            hold_cnt  <= (frame.data_cnt == 2'h1) ? BYTE_PROGRAM_CYCLES
                                                                   : PAGE_PROGRAM_CYCLES;
                        end else if (is_blk4) begin
                            walk_ptr  <= frame.addr & `MASK_4K;
                            walk_left <= `LEN_4K;
                            hold_cnt  <= ERASE_4K_CYCLES;
                        end else if (is_blk32) begin
                            walk_ptr  <= frame.addr & `MASK_32K;
                            walk_left <= `LEN_32K;
                            hold_cnt  <= ERASE_32K_CYCLES;
                        end else begin
                            walk_ptr  <= 16'h0000;
                            walk_left <= `LEN_CHIP;
                            hold_cnt  <= CHIP_ERASE_CYCLES;
                        end
                    end
                end
                spi_flash_pkg::CORE_WALK, spi_flash_pkg::CORE_HOLD: begin
                    if (hold_cnt != 32'h00000000) begin
                        hold_cnt <= hold_cnt - 32'h00000001;
                    end
                    if (state == spi_flash_pkg::CORE_WALK) begin
                        walk_ptr  <= walk_ptr + 16'h0001;
                        walk_left <= walk_left - 17'h00001;
                    end
                    // busy ends only when both time and update are done
                    if ((walk_last || state == spi_flash_pkg::CORE_HOLD)
                        && hold_cnt <= 32'h00000001) begin
                        state <= spi_flash_pkg::CORE_IDLE;
                        busy  <= 1'b0;
                    end else if (walk_last) begin
                        state <= spi_flash_pkg::CORE_HOLD;
                    end
                end
                default: begin
                    state <= spi_flash_pkg::CORE_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // array update; programming only clears bits, erase sets them all
    always_ff @(posedge core_clk) begin
        if (state == spi_flash_pkg::CORE_WALK) begin
            if (!walk_prog) begin
                mem[walk_ptr] <= `ERASED_BYTE;
            end else if (page_written[walk_ptr[7:0]]) begin
                mem[walk_ptr] <= mem[walk_ptr] & page_buf[walk_ptr[7:0]];
            end
        end
    end

    // read-back check one cycle after each write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chk_valid <= 1'b0;
            chk_addr  <= 16'h0000;
            chk_val   <= 8'h00;
        end else begin
            chk_valid <= (state == spi_flash_pkg::CORE_WALK)
                         && (!walk_prog || page_written[walk_ptr[7:0]]);
            chk_addr  <= walk_ptr;
            chk_val   <= walk_prog ? page_buf[walk_ptr[7:0]] : `ERASED_BYTE;
        end
    end

    // error flag: cleared when a new cycle starts, set by a failed check
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            program_erase_error_flag <= 1'b0;
        end else if (chk_valid && mem[chk_addr] != chk_val) begin
            program_erase_error_flag <= 1'b1;
        end else if (pe_start) begin
            program_erase_error_flag <= 1'b0;
        end
    end

endmodule : spi_flash_engine

`default_nettype wire

// ===== verification/spi_flash_engine_props.sv
// checker: busy, latch and error flag against frame and protect inputs
// assumes only the engine's top ports; bound at the foot
`timescale 1ns/100ps
`default_nettype none
module spi_flash_engine_props #(
    parameter int unsigned BYTE_PROGRAM_CYCLES = 1000
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic array_protect,
    input wire logic so_oe,
    input wire logic busy,
    input wire logic write_enable_latch,
    input wire logic program_erase_error_flag
);
    logic [31:0] busy_len;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // length of the running busy stretch, zero when idle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            busy_len <= 32'h0;
        else
            busy_len <= busy ? busy_len + 32'h1 : 32'h0;
    end
    a_oe_when_sel: assert property (so_oe |-> !cs_n)
        else $error("so_oe high while deselected");
    a_latch_drop_start: assert property ($rose(busy) |-> !write_enable_latch)
        else $error("latch still set at cycle start");
    a_latch_low_busy: assert property (busy |-> !write_enable_latch)
        else $error("latch set during cycle");
    a_start_needs_latch: assert property ($rose(busy) |-> $past(write_enable_latch))
        else $error("cycle started without latch");
    a_start_unprot: assert property ($rose(busy) |-> !array_protect)
        else $error("cycle started while protected");
    a_start_desel: assert property ($rose(busy) |-> cs_n && $past(cs_n, 3))
        else $error("cycle started before deselect");
    a_busy_len_min: assert property ($fell(busy) |-> busy_len >= 32'(BYTE_PROGRAM_CYCLES))
        else $error("busy too short");
    a_err_in_cycle: assert property ($rose(program_erase_error_flag) |-> busy)
        else $error("error flag outside a cycle");
endmodule : spi_flash_engine_props
bind spi_flash_engine spi_flash_engine_props #(
    .BYTE_PROGRAM_CYCLES(BYTE_PROGRAM_CYCLES)
) u_props (
    .core_clk(core_clk),
    .rst(rst),
    .cs_n(cs_n),
    .array_protect(array_protect),
    .so_oe(so_oe),
    .busy(busy),
    .write_enable_latch(write_enable_latch),
    .program_erase_error_flag(program_erase_error_flag)
);
`default_nettype wire

// ===== verification/spi_host_model.sv
// host model: mode 0 frames, sck 125 ns, still between frames
// assumes the bench calls frame() and watches got for read bytes
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    output var logic cs_n,
    output var logic sck,
    output var logic si,
    input  wire logic so,
    input  wire logic so_oe
);
    logic [7:0] rx_byte;
    event       got;
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    // bytes out, then nrx read bytes of random filler, then tail loose bits
    task automatic frame(input logic [7:0] tx[$], input int nrx, input int tail);
        int n;
        n = tx.size();
        for (int k = 0; k < nrx; k++)
            tx.push_back(8'($urandom));
        cs_n = 1'b0;
        #100;
        for (int i = 0; i < 8 * tx.size() + tail; i++) begin
            si = (i < 8 * tx.size()) ? tx[i / 8][7 - i % 8] : 1'b0;
            #62.5 sck = 1'b1;
            rx_byte[7 - i % 8] = so_oe ? so : 1'bx;
            if (i % 8 == 7 && i / 8 >= n)
                -> got;
            #62.5 sck = 1'b0;
        end
        #60 cs_n = 1'b1;
        si = ~si; // released line must not keep its value
        #1000;
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

// ===== verification/spi_flash_engine_tb.sv
// bench: host model drives frames, read bytes checked against noted values
// assumes short self-timed counts so the run stays small
`timescale 1ns/100ps
`default_nettype none
module spi_flash_engine_tb;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       array_protect = 1'b0;
    logic       cs_n, sck, si, so, so_oe, busy, latch, err;
    logic [7:0] exp_q[$];
    logic [7:0] tx[$];
    logic [7:0] pg[258];
    logic [7:0] d[4];
    logic [7:0] ops[6] = '{8'h52, 8'hD8, 8'h62, 8'hC7, 8'h02, 8'h20};
    int         failures = 0;
    int         n_compared = 0;
    always #50 core_clk = ~core_clk;
    // 32K erase is only ever refused here, so its count keeps the default
    spi_flash_engine #(.PAGE_PROGRAM_CYCLES(300), .BYTE_PROGRAM_CYCLES(280),
        .ERASE_4K_CYCLES(300), .CHIP_ERASE_CYCLES(300)) DUT (
        .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
        .array_protect(array_protect), .so(so), .so_oe(so_oe), .busy(busy),
        .write_enable_latch(latch), .program_erase_error_flag(err));
    spi_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    // read bytes arrive in the order they were noted
    always @(host.got) check(host.rx_byte, exp_q.pop_front());
    task automatic complete_run;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    task automatic stat(input logic [7:0] want);
        exp_q.push_back(want);
        host.frame('{8'h05}, 1, 0);
    endtask : stat
    // write enable first, then the command frame
    task automatic wcmd(input logic [7:0] b[$], input int tail);
        host.frame('{8'h06}, 0, 0);
        host.frame(b, 0, tail);
    endtask : wcmd
    task automatic rd(input logic [7:0] op, input logic [15:0] a, input logic [7:0] w[$]);
        logic [7:0] t[$];
        foreach (w[k]) exp_q.push_back(w[k]);
        t = '{op, 8'($urandom), a[15:8], a[7:0]};
        if (op == 8'h0B)
            t.push_back(8'h00);
        host.frame(t, w.size(), 0);
    endtask : rd
    // poll busy with a bound; a hang ends the run
    task automatic wait_idle;
        int n;
        for (n = 0; n < 70000 && busy !== 1'b0; n++) @(negedge core_clk);
        if (n == 70000) begin
            failures++;
            complete_run();
        end
    endtask : wait_idle
    initial begin
        void'($urandom(32'h1b82bb0b));
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        stat(8'h00);
        host.frame('{8'h06}, 0, 0);
        stat(8'h02);
        check({7'h00, latch}, 8'h01);
        host.frame('{8'h04}, 0, 0);
        stat(8'h00);
        @(posedge core_clk) array_protect <= 1'b1;
        foreach (ops[i]) begin
            wcmd('{ops[i], 8'h00, 8'h80, 8'h00, 8'h5A}, 0);
            stat(8'h00);
        end
        @(posedge core_clk) array_protect <= 1'b0;
        $display("protected refusals done");
        wcmd('{8'h60, 8'h12}, 0);
        stat(8'h01);
        check({7'h00, busy}, 8'h01);
        wait_idle();
        wcmd('{8'h02, 8'h00, 8'h02, 8'h00, 8'h33}, 3);
        stat(8'h00);
        wcmd('{8'h20, 8'h00, 8'h02}, 0);
        stat(8'h00);
        wcmd('{8'hC7}, 4);
        stat(8'h00);
        host.frame('{8'h02, 8'h00, 8'h03, 8'h00, 8'h33}, 0, 0);
        host.frame('{8'h9F, 8'h06}, 0, 0);
        stat(8'h00);
        rd(8'h03, 16'h0200, '{8'hFF});
        rd(8'h03, 16'h0300, '{8'hFF});
        $display("aborts done");
        foreach (d[i]) d[i] = 8'($urandom);
        wcmd('{8'h02, 8'h00, 8'hFF, 8'hFE, d[0], d[1], d[2]}, 0);
        stat(8'h01);
        wait_idle();
        wcmd('{8'h02, 8'h00, 8'h00, 8'h00, d[3]}, 0);
        wait_idle();
        rd(8'h0B, 16'hFFFE, '{d[0], d[1], d[3], 8'hFF});
        rd(8'h03, 16'hFF00, '{d[2], 8'hFF});
        foreach (pg[i]) pg[i] = 8'($urandom);
        pg[256] = pg[256] & 8'h7F;
        tx = '{8'h02, 8'h00, 8'h01, 8'h00};
        foreach (pg[i]) tx.push_back(pg[i]);
        wcmd(tx, 0);
        wait_idle();
        rd(8'h0B, 16'h0100, '{pg[256], pg[257], pg[2], pg[3]});
        rd(8'h03, 16'h01FF, '{pg[255]});
        $display("program done");
        // a zero bit cannot go back to one, so verify must flag it
        wcmd('{8'h02, 8'h00, 8'h01, 8'h00, 8'hFF}, 0);
        wait_idle();
        stat(8'h20);
        check({7'h00, err}, 8'h01);
        wcmd('{8'h20, 8'h00, 8'h01, 8'h23}, 0);
        wait_idle();
        stat(8'h00);
        rd(8'h03, 16'h0000, '{8'hFF});
        rd(8'h0B, 16'h0100, '{8'hFF, 8'hFF});
        host.frame('{8'h03, 8'h00, 8'h00, 8'h00}, 0, 5);
        check({7'h00, so_oe}, 8'h00);
        $display("erase and read cut done");
        complete_run();
    end
endmodule : spi_flash_engine_tb
`default_nettype wire
